// ===== dv/ohcirb_bank_monitor.sv
// concurrent checks on the link register bank ports
`timescale 1ns/10ps
`default_nettype none
module ohcirb_bank_monitor
  import ohcirb_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_cfg_wr,
  input wire logic        i_cfg_rd,
  input wire logic [7:0]  i_cfg_addr,
  input wire logic [3:0]  i_cfg_be,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic        o_cfg_rvalid,
  input wire logic        i_mem_wr,
  input wire logic        i_mem_rd,
  input wire logic        o_mem_claim,
  input wire logic        o_mem_rvalid,
  input wire logic        i_eeprom_load,
  input wire logic [7:0]  i_eeprom_enh,
  input wire logic        o_phy_program_allow,
  input wire logic [31:0] o_host_ctrl,
  input wire logic [15:0] o_subsystem_device_alias,
  input wire logic [15:0] o_subsystem_maker_alias
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_cfg_read_answer: assert property (i_cfg_rd |=> o_cfg_rvalid) else $error("cfg read not answered");
  a_cfg_rvalid_cause: assert property (o_cfg_rvalid |-> $past(i_cfg_rd)) else $error("cfg rvalid without read");
  a_mem_read_answer: assert property ($past(i_mem_rd) && o_mem_claim |=> o_mem_rvalid)
    else $error("mem read claimed but no data");
  a_mem_rvalid_cause: assert property (o_mem_rvalid |-> $past(o_mem_claim)) else $error("mem rvalid unclaimed");
  a_claim_cause: assert property (o_mem_claim |-> $past(i_mem_wr || i_mem_rd)) else $error("claim without strobe");
  a_alias_split: assert property (i_cfg_wr && i_cfg_addr == CFG_SUBSYS_ALIAS_OFS && i_cfg_be == 4'hF
    |=> ##1 {o_subsystem_device_alias, o_subsystem_maker_alias} == $past(i_cfg_wdata, 2))
    else $error("alias outputs do not follow write");
  a_lfc_reserved_zero: assert property (i_cfg_rd && i_cfg_addr == CFG_LINK_FEATURE_OFS
    |=> (o_cfg_rdata & ~LFC_RW_MASK) == 32'h0000_0000) else $error("link feature reserved bits set");
  a_phy_prog_mirror: assert property (o_phy_program_allow == o_host_ctrl[HCC_PHY_PROGRAM_BIT])
    else $error("phy program allow differs from host ctrl");
  a_eeprom_phy: assert property (i_eeprom_load |=> ##1 o_phy_program_allow == $past(i_eeprom_enh[6], 2))
    else $error("eeprom bit not reflected");
endmodule // ohcirb_bank_monitor
`default_nettype wire

// ===== dv/ohcirb_bank_test.sv
// self-checking testbench for the link register bank
`timescale 1ns/10ps
`default_nettype none
module ohcirb_bank_test;
  import ohcirb_pkg::*;
  logic        i_clk, i_rstn, i_cfg_wr, i_cfg_rd, i_mem_wr, i_mem_rd, i_eeprom_load;
  logic [7:0]  i_cfg_addr, i_eeprom_enh;
  logic [3:0]  i_cfg_be, i_mem_be;
  logic [31:0] i_cfg_wdata, i_mem_addr, i_mem_wdata, i_int_events, i_posted_addr_lo, i_posted_addr_hi;
  logic [31:0] o_cfg_rdata, o_mem_rdata, o_host_ctrl;
  logic        o_cfg_rvalid, o_mem_claim, o_mem_rvalid, o_phy_accel_support, o_phy_program_allow;
  logic        o_store_and_forward;
  logic [15:0] o_subsystem_device_alias, o_subsystem_maker_alias;
  logic [31:0] seed, base, r1, r2, rd;
  logic        claimed;
  int          n_errors, num_checks;

  ohcirb_bank dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd),
    .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be), .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata),
    .o_cfg_rvalid(o_cfg_rvalid), .i_mem_wr(i_mem_wr), .i_mem_rd(i_mem_rd), .i_mem_addr(i_mem_addr),
    .i_mem_be(i_mem_be), .i_mem_wdata(i_mem_wdata), .o_mem_claim(o_mem_claim), .o_mem_rdata(o_mem_rdata),
    .o_mem_rvalid(o_mem_rvalid), .i_eeprom_load(i_eeprom_load), .i_eeprom_enh(i_eeprom_enh),
    .i_int_events(i_int_events), .i_posted_addr_lo(i_posted_addr_lo), .i_posted_addr_hi(i_posted_addr_hi),
    .o_phy_accel_support(o_phy_accel_support), .o_phy_program_allow(o_phy_program_allow),
    .o_host_ctrl(o_host_ctrl), .o_store_and_forward(o_store_and_forward),
    .o_subsystem_device_alias(o_subsystem_device_alias), .o_subsystem_maker_alias(o_subsystem_maker_alias));

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge i_clk);
    i_cfg_wr = 1'b1; i_cfg_addr = a; i_cfg_wdata = d;
    @(negedge i_clk);
    i_cfg_wr = 1'b0;
  endtask

  task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge i_clk);
    i_cfg_rd = 1'b1; i_cfg_addr = a;
    @(negedge i_clk);
    i_cfg_rd = 1'b0;
    d = 32'hDEAD_BEEF;
    for (int k = 0; k < 4; k++) begin
      if (o_cfg_rvalid === 1'b1) begin
        d = o_cfg_rdata;
        break;
      end
      @(negedge i_clk);
    end
  endtask

  task automatic mem_wr(input logic [10:0] ofs, input logic [31:0] d);
    @(negedge i_clk);
    i_mem_wr = 1'b1; i_mem_addr = base | {21'h0, ofs}; i_mem_wdata = d;
    @(negedge i_clk);
    i_mem_wr = 1'b0;
  endtask

  // miss test passes a full address, so the base is not added here
  task automatic mem_rd(input logic [31:0] a, output logic [31:0] d, output logic c);
    @(negedge i_clk);
    i_mem_rd = 1'b1; i_mem_addr = a;
    @(negedge i_clk);
    i_mem_rd = 1'b0;
    c = o_mem_claim;
    d = 32'hDEAD_BEEF;
    for (int k = 0; k < 4; k++) begin
      if (o_mem_rvalid === 1'b1) begin
        d = o_mem_rdata;
        break;
      end
      @(negedge i_clk);
    end
  endtask

  task automatic win_rd(input string name, input logic [10:0] ofs, input logic [31:0] exp);
    mem_rd(base | {21'h0, ofs}, rd, claimed);
    chk(name, exp, rd);
  endtask

  initial begin
    repeat (6000) @(posedge i_clk);
    n_errors++;
    $display("ERROR watchdog expected done seen hang");
    final_report();
  end

  initial begin
    seed = 32'h3cff25f5;
    {i_cfg_wr, i_cfg_rd, i_mem_wr, i_mem_rd, i_eeprom_load} = 5'h00;
    i_cfg_addr = 8'h00; i_eeprom_enh = 8'h00; i_cfg_be = 4'hF; i_mem_be = 4'hF;
    i_cfg_wdata = 32'h0; i_mem_addr = 32'h0; i_mem_wdata = 32'h0; i_int_events = 32'h0;
    i_posted_addr_lo = rnd(); i_posted_addr_hi = rnd();
    n_errors = 0; num_checks = 0; base = 32'h0;
    i_rstn = 1'b0;
    repeat (4) @(negedge i_clk);
    i_rstn = 1'b1;
    chk("saf_reset", 32'h1, {31'h0, o_store_and_forward});
    cfg_rd(CFG_SUBSYS_ALIAS_OFS, rd);
    chk("alias_reset", SUBSYS_ALIAS_RESET, rd);
    for (int i = 0; i < 3; i++) begin
      r1 = (i == 0) ? 32'hFFFF_0000 : rnd();
      cfg_wr(CFG_SUBSYS_ALIAS_OFS, r1);
      cfg_rd(CFG_SUBSYS_ALIAS_OFS, rd);
      chk("alias_read", r1, rd);
      chk("device_alias", {16'h0, r1[31:16]}, {16'h0, o_subsystem_device_alias});
      chk("maker_alias", {16'h0, r1[15:0]}, {16'h0, o_subsystem_maker_alias});
    end
    $display("test alias done");
    cfg_wr(CFG_LINK_FEATURE_OFS, 32'hFFFF_FFFF);
    cfg_rd(CFG_LINK_FEATURE_OFS, rd);
    chk("lfc_read", LFC_RW_MASK, rd);
    chk("accel_on", 32'h1, {31'h0, o_phy_accel_support});
    cfg_wr(CFG_LINK_FEATURE_OFS, 32'hFFFF_FFFD);
    cfg_rd(CFG_LINK_FEATURE_OFS, rd);
    chk("lfc_clear", 32'h0, rd);
    chk("accel_off", 32'h0, {31'h0, o_phy_accel_support});
    $display("test link feature done");
    r1 = rnd() | 32'h8000_0000;
    cfg_wr(CFG_OHCI_BASE_OFS, r1);
    base = r1 & OHCI_BASE_MASK;
    cfg_rd(CFG_OHCI_BASE_OFS, rd);
    chk("base_read", base, rd);
    mem_rd(base ^ 32'h0000_0800, rd, claimed);
    chk("miss_claim", 32'h0, {31'h0, claimed});
    mem_rd(base | 32'h0000_07FC, rd, claimed);
    chk("top_claim", 32'h1, {31'h0, claimed});
    $display("test window decode done");
    r1 = rnd();
    r2 = rnd();
    mem_wr(OFS_HOST_CTRL_SET, r1);
    mem_wr(OFS_HOST_CTRL_SET, 32'h0);
    win_rd("hc_set_read", OFS_HOST_CTRL_SET, r1);
    win_rd("hc_clr_read", OFS_HOST_CTRL_CLEAR, r1);
    mem_wr(OFS_HOST_CTRL_CLEAR, r2);
    mem_wr(OFS_HOST_CTRL_CLEAR, 32'h0);
    win_rd("hc_after_clr", OFS_HOST_CTRL_SET, r1 & ~r2);
    chk("hc_port", r1 & ~r2, o_host_ctrl);
    mem_wr(OFS_HOST_CTRL_CLEAR, 32'hFFFF_FFFF);
    @(negedge i_clk);
    i_eeprom_load = 1'b1; i_eeprom_enh = 8'h40;
    @(negedge i_clk);
    i_eeprom_load = 1'b0;
    repeat (2) @(negedge i_clk);
    chk("phy_prog_allow", 32'h1, {31'h0, o_phy_program_allow});
    @(negedge i_clk);
    i_eeprom_load = 1'b1;
    i_eeprom_enh = 8'hBF;
    @(negedge i_clk);
    i_eeprom_load = 1'b0;
    repeat (2) @(negedge i_clk);
    chk("phy_prog_block", 32'h0, {31'h0, o_phy_program_allow});
    $display("test set clear done");
    @(negedge i_clk);
    i_int_events = 32'h0000_00A5;
    @(negedge i_clk);
    i_int_events = 32'h0;
    mem_wr(OFS_INT_MASK_SET, 32'h0000_000F);
    win_rd("event_raw", OFS_INT_EVENT_SET, 32'h0000_00A5);
    win_rd("event_masked", OFS_INT_EVENT_CLEAR, 32'h0000_0005);
    mem_wr(OFS_INT_EVENT_CLEAR, 32'h0000_0001);
    win_rd("event_cleared", OFS_INT_EVENT_SET, 32'h0000_00A4);
    @(negedge i_clk);
    i_int_events = 32'h0000_0010;
    i_mem_addr = base | {21'h0, OFS_INT_EVENT_CLEAR};
    i_mem_wdata = 32'h0000_0030;
    i_mem_wr = 1'b1;
    @(negedge i_clk);
    i_mem_wr = 1'b0;
    i_int_events = 32'h0;
    win_rd("event_set_wins", OFS_INT_EVENT_SET, 32'h0000_0094);
    $display("test masked read done");
    for (int i = 0; i < 3; i++) begin
      r1 = rnd();
      r2 = rnd();
      mem_wr(OFS_UID_ROM_PORT, r1);
      mem_wr(OFS_CFG_ROM_MAP, r2);
      win_rd("rom_port_read", OFS_UID_ROM_PORT, r1);
      win_rd("rom_map_read", OFS_CFG_ROM_MAP, r2);
    end
    for (int i = 0; i < 7; i++) begin
      r2 = {21'h0, 11'h02C} + 32'(i < 2 ? 4 * i : i < 5 ? 24 + 4 * (i - 2) : 44 + 4 * (i - 5));
      mem_wr(r2[10:0], rnd());
      win_rd("reserved_zero", r2[10:0], 32'h0);
    end
    win_rd("rom_port_keep", OFS_UID_ROM_PORT, r1);
    mem_wr(OFS_POSTED_WR_LOWER, ~i_posted_addr_lo);
    win_rd("posted_lo", OFS_POSTED_WR_LOWER, i_posted_addr_lo);
    win_rd("posted_hi", OFS_POSTED_WR_UPPER, i_posted_addr_hi);
    $display("test reserved done");
    r1 = rnd() | 32'h1;
    mem_wr(OFS_ASYNC_TX_RETRY, r1);
    win_rd("retry_read", OFS_ASYNC_TX_RETRY, r1);
    repeat (2) @(negedge i_clk);
    chk("saf_nonzero", 32'h0, {31'h0, o_store_and_forward});
    mem_wr(OFS_ASYNC_TX_RETRY, 32'h0);
    repeat (2) @(negedge i_clk);
    chk("saf_zero", 32'h1, {31'h0, o_store_and_forward});
    $display("test retry done");
    final_report();
  end
endmodule // ohcirb_bank_test

bind ohcirb_bank ohcirb_bank_monitor mon (.i_clk(i_clk), .i_rstn(i_rstn), .i_cfg_wr(i_cfg_wr),
  .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be), .i_cfg_wdata(i_cfg_wdata),
  .o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid), .i_mem_wr(i_mem_wr), .i_mem_rd(i_mem_rd),
  .o_mem_claim(o_mem_claim), .o_mem_rvalid(o_mem_rvalid), .i_eeprom_load(i_eeprom_load),
  .i_eeprom_enh(i_eeprom_enh), .o_phy_program_allow(o_phy_program_allow), .o_host_ctrl(o_host_ctrl),
  .o_subsystem_device_alias(o_subsystem_device_alias), .o_subsystem_maker_alias(o_subsystem_maker_alias));
`default_nettype wire

// ===== rtl/ohcirb_bank.sv
// link register bank: config-space link registers and the base of the memory window
// Notes on behaviour
// - accel enable bit tells phy of support
// - bit 6 reads zero; eeprom drives phy program
// - bits 5 to 2 read zero
// - bit 0 reads zero
// - alias write updates ids; resets zero
// - alias register reads back last write
// - upper half device alias, lower maker
// - window decoded as 2K region at base
// - set address: ones set, zeros keep
// - clear address: ones clear, zeros keep
// - set or clear address reads contents, except event clear
// - event clear address reads masked contents
// - zero retry register forces store-and-forward
`timescale 1ns/10ps
`default_nettype none
module ohcirb_bank
  import ohcirb_pkg::*;
#(
  parameter logic [31:0] IFACE_VERSION = 32'h0000_0000,  // arbitrary value
  parameter logic [31:0] BUS_ID_VALUE  = 32'h0000_0000,  // arbitrary value
  parameter logic [31:0] MAKER_ID      = 32'h0000_0000   // arbitrary value
) (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [3:0]  i_cfg_be,
  input  wire logic [31:0] i_cfg_wdata,
  output logic      [31:0] o_cfg_rdata,
  output logic             o_cfg_rvalid,
  input  wire logic        i_mem_wr,
  input  wire logic        i_mem_rd,
  input  wire logic [31:0] i_mem_addr,
  input  wire logic [3:0]  i_mem_be,
  input  wire logic [31:0] i_mem_wdata,
  output logic             o_mem_claim,
  output logic      [31:0] o_mem_rdata,
  output logic             o_mem_rvalid,
  input  wire logic        i_eeprom_load,
  input  wire logic [7:0]  i_eeprom_enh,
  input  wire logic [31:0] i_int_events,
  input  wire logic [31:0] i_posted_addr_lo,
  input  wire logic [31:0] i_posted_addr_hi,
  output logic             o_phy_accel_support,
  output logic             o_phy_program_allow,
  output logic      [31:0] o_host_ctrl,
  output logic             o_store_and_forward,
  output logic      [15:0] o_subsystem_device_alias,
  output logic      [15:0] o_subsystem_maker_alias
);

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // configuration space state
  logic [31:0] ohci_base, next_ohci_base;
  logic [31:0] link_feature, next_link_feature;
  logic [31:0] subsys_alias, next_subsys_alias;
  logic [31:0] next_cfg_rdata;
  logic        next_cfg_rvalid;

  always_comb begin
    next_ohci_base    = ohci_base;
    next_link_feature = link_feature;
    next_subsys_alias = subsys_alias;
    next_cfg_rdata    = o_cfg_rdata;
    next_cfg_rvalid   = i_cfg_rd;
    if (i_cfg_wr) begin
      unique case (i_cfg_addr)
        CFG_OHCI_BASE_OFS: begin
          next_ohci_base = ((ohci_base & ~lane_mask(i_cfg_be)) | (i_cfg_wdata & lane_mask(i_cfg_be)))
                           & OHCI_BASE_MASK;
        end
        CFG_LINK_FEATURE_OFS: begin
          // only the accel bit is storage; bits 6, 5..2 and 0 never hold a value
          next_link_feature = ((link_feature & ~lane_mask(i_cfg_be)) | (i_cfg_wdata & lane_mask(i_cfg_be)))
                              & LFC_RW_MASK;
        end
        CFG_SUBSYS_ALIAS_OFS: begin
          next_subsys_alias = (subsys_alias & ~lane_mask(i_cfg_be)) | (i_cfg_wdata & lane_mask(i_cfg_be));
        end
        default: begin
        end
      endcase
    end
    // a read in the cycle after a write already sees the stored value
    if (i_cfg_rd) begin
      unique case (i_cfg_addr)
        CFG_OHCI_BASE_OFS:    next_cfg_rdata = ohci_base;
        CFG_LINK_FEATURE_OFS: next_cfg_rdata = link_feature & LFC_RW_MASK;
        CFG_SUBSYS_ALIAS_OFS: next_cfg_rdata = subsys_alias;
        default:              next_cfg_rdata = ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ohci_base    <= ZERO_WORD;
      link_feature <= ZERO_WORD;
      subsys_alias <= SUBSYS_ALIAS_RESET;
      o_cfg_rdata  <= ZERO_WORD;
      o_cfg_rvalid <= 1'b0;
    end else begin
      ohci_base    <= next_ohci_base;
      link_feature <= next_link_feature;
      subsys_alias <= next_subsys_alias;
      o_cfg_rdata  <= next_cfg_rdata;
      o_cfg_rvalid <= next_cfg_rvalid;
    end
  end

  // memory window decode
  logic        win_hit;
  logic [10:0] win_ofs;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic        store_word;

  always_comb begin
    // base resets to zero, so the window answers at address zero until moved
    win_hit = (i_mem_addr[31:WIN_ADDR_BITS] == ohci_base[31:WIN_ADDR_BITS]);
    // address bits 1..0 are ignored: offsets are word aligned and the byte enables pick the lanes written
    win_ofs = {i_mem_addr[WIN_ADDR_BITS-1:2], 2'b00};
    wr_hit  = i_mem_wr && win_hit;
    rd_hit  = i_mem_rd && win_hit;
    wmask   = lane_mask(i_mem_be);
    wbits   = i_mem_wdata & wmask;
    unique case (win_ofs)
      OFS_UID_ROM_PORT, OFS_CSR_VALUE, OFS_CSR_COMPARE, OFS_CSR_CTRL, OFS_CFG_ROM_HEADER,
      OFS_BUS_OPTIONS, OFS_UID_UPPER, OFS_UID_LOWER, OFS_CFG_ROM_MAP: store_word = 1'b1;
      default:                                                        store_word = 1'b0;
    endcase
  end

  // window state held here rather than in the store: it steers logic directly
  logic [31:0] retry_limits, next_retry_limits;
  logic [31:0] host_ctrl, next_host_ctrl;
  logic [31:0] int_event, next_int_event;
  // mask only shapes the clear-side read; no interrupt line leaves this block
  logic [31:0] int_mask, next_int_mask;
  logic [31:0] ev_set;
  logic [31:0] ev_clr;

  always_comb begin
    next_retry_limits = retry_limits;
    next_host_ctrl    = host_ctrl;
    next_int_mask     = int_mask;
    ev_set            = i_int_events;
    ev_clr            = ZERO_WORD;
    if (wr_hit) begin
      unique case (win_ofs)
        OFS_ASYNC_TX_RETRY:  next_retry_limits = (retry_limits & ~wmask) | wbits;
        OFS_HOST_CTRL_SET:   next_host_ctrl    = host_ctrl | wbits;
        OFS_HOST_CTRL_CLEAR: next_host_ctrl    = host_ctrl & ~wbits;
        OFS_INT_EVENT_SET:   ev_set            = i_int_events | wbits;
        OFS_INT_EVENT_CLEAR: ev_clr            = wbits;
        OFS_INT_MASK_SET:    next_int_mask     = int_mask | wbits;
        OFS_INT_MASK_CLEAR:  next_int_mask     = int_mask & ~wbits;
        default: begin
          // reserved and read-only offsets drop the write
        end
      endcase
    end
    // a hardware event in the clearing cycle survives the clear
    next_int_event = (int_event & ~ev_clr) | ev_set;
    // a load in the same cycle as a host ctrl write wins for bit 23
    if (i_eeprom_load) begin
      next_host_ctrl[HCC_PHY_PROGRAM_BIT] = i_eeprom_enh[LFC_EEPROM_PHY_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      retry_limits <= ASYNC_TX_RETRY_RESET;
      host_ctrl    <= HCC_RESET;
      int_event    <= INT_RESET;
      int_mask     <= INT_RESET;
    end else begin
      retry_limits <= next_retry_limits;
      host_ctrl    <= next_host_ctrl;
      int_event    <= next_int_event;
      int_mask     <= next_int_mask;
    end
  end

  // store read data is registered, so local words are staged one cycle to line up
  logic [31:0] store_rdata;

  ohcirb_store #(
    .WIDTH (32),
    .DEPTH (STORE_DEPTH),
    .AW    (STORE_AW)
  ) u_store (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_we    (wr_hit && store_word),
    .i_waddr (win_ofs[STORE_AW+1:2]),
    .i_be    (i_mem_be),
    .i_wdata (i_mem_wdata),
    .i_raddr (win_ofs[STORE_AW+1:2]),
    .o_rdata (store_rdata)
  );

  // read path: stage one picks local data, stage two merges with the store word
  logic [31:0] local_rdata, next_local_rdata;
  logic        rd_from_store, next_rd_from_store;
  logic        rd_pend, next_rd_pend;
  logic [31:0] next_mem_rdata;
  logic        next_mem_rvalid;
  logic        next_mem_claim;

  always_comb begin
    next_rd_pend       = rd_hit;
    next_rd_from_store = rd_hit && store_word;
    unique case (win_ofs)
      OFS_IFACE_VERSION:   next_local_rdata = IFACE_VERSION;
      OFS_ASYNC_TX_RETRY:  next_local_rdata = retry_limits;
      OFS_BUS_IDENTIFIER:  next_local_rdata = BUS_ID_VALUE;
      OFS_POSTED_WR_LOWER: next_local_rdata = i_posted_addr_lo;
      OFS_POSTED_WR_UPPER: next_local_rdata = i_posted_addr_hi;
      OFS_MAKER_ID:        next_local_rdata = MAKER_ID;
      OFS_HOST_CTRL_SET,
      OFS_HOST_CTRL_CLEAR: next_local_rdata = host_ctrl;
      OFS_INT_EVENT_SET:   next_local_rdata = int_event;
      OFS_INT_EVENT_CLEAR: next_local_rdata = int_event & int_mask;
      OFS_INT_MASK_SET,
      OFS_INT_MASK_CLEAR:  next_local_rdata = int_mask;
      default:             next_local_rdata = ZERO_WORD;
    endcase
    next_mem_rvalid = rd_pend;
    next_mem_claim  = wr_hit || rd_hit;
    // read data holds between reads, so a slow sampler still finds the word
    next_mem_rdata  = o_mem_rdata;
    if (rd_pend) begin
      next_mem_rdata = rd_from_store ? store_rdata : local_rdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      local_rdata   <= ZERO_WORD;
      rd_from_store <= 1'b0;
      rd_pend       <= 1'b0;
      o_mem_rdata   <= ZERO_WORD;
      o_mem_rvalid  <= 1'b0;
      o_mem_claim   <= 1'b0;
    end else begin
      local_rdata   <= next_local_rdata;
      rd_from_store <= next_rd_from_store;
      rd_pend       <= next_rd_pend;
      o_mem_rdata   <= next_mem_rdata;
      o_mem_rvalid  <= next_mem_rvalid;
      o_mem_claim   <= next_mem_claim;
    end
  end

  // link side outputs
  logic        next_store_and_forward;
  logic        next_phy_accel_support;
  logic        next_phy_program_allow;
  logic [31:0] next_host_ctrl_out;
  logic [15:0] next_device_alias;
  logic [15:0] next_maker_alias;

  always_comb begin
    // a zero retry limit leaves no second try after an underrun
    next_store_and_forward = (retry_limits == ZERO_WORD);
    next_phy_accel_support = link_feature[LFC_ACCEL_BIT];
    next_phy_program_allow = host_ctrl[HCC_PHY_PROGRAM_BIT];
    next_host_ctrl_out     = host_ctrl;
    next_device_alias      = subsys_alias[31:16];
    next_maker_alias       = subsys_alias[15:0];
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_phy_accel_support      <= 1'b0;
      o_phy_program_allow      <= 1'b0;
      o_host_ctrl              <= HCC_RESET;
      o_store_and_forward      <= 1'b1;
      o_subsystem_device_alias <= SUBSYS_ALIAS_RESET[31:16];
      o_subsystem_maker_alias  <= SUBSYS_ALIAS_RESET[15:0];
    end else begin
      o_phy_accel_support      <= next_phy_accel_support;
      o_phy_program_allow      <= next_phy_program_allow;
      o_host_ctrl              <= next_host_ctrl_out;
      o_store_and_forward      <= next_store_and_forward;
      o_subsystem_device_alias <= next_device_alias;
      o_subsystem_maker_alias  <= next_maker_alias;
    end
  end

endmodule // ohcirb_bank
`default_nettype wire

// ===== rtl/ohcirb_pkg.sv
// constants for the link register bank: offsets, field positions, reset values
package ohcirb_pkg;

  // pci configuration space, byte offsets
  localparam logic [7:0]  CFG_OHCI_BASE_OFS    = 8'h10;
  localparam logic [7:0]  CFG_LINK_FEATURE_OFS = 8'hF4;
  localparam logic [7:0]  CFG_SUBSYS_ALIAS_OFS = 8'hF8;
  localparam logic [31:0] SUBSYS_ALIAS_RESET   = 32'h0000_0000;

  // memory window: 2K bytes, base register keeps address bits 31..11
  localparam int          WIN_ADDR_BITS        = 11;
  localparam logic [31:0] OHCI_BASE_MASK       = 32'hFFFF_F800;

  // link feature control fields
  localparam int          LFC_ACCEL_BIT        = 1;
  localparam int          LFC_EEPROM_PHY_BIT   = 6;
  localparam logic [31:0] LFC_RW_MASK          = 32'h0000_0002;

  // host controller control fields
  localparam int          HCC_PHY_PROGRAM_BIT  = 23;
  localparam logic [31:0] HCC_RESET            = 32'h0000_0000;

  // window byte offsets
  localparam logic [10:0] OFS_IFACE_VERSION    = 11'h000;
  localparam logic [10:0] OFS_UID_ROM_PORT     = 11'h004;
  localparam logic [10:0] OFS_ASYNC_TX_RETRY   = 11'h008;
  localparam logic [10:0] OFS_CSR_VALUE        = 11'h00C;
  localparam logic [10:0] OFS_CSR_COMPARE      = 11'h010;
  localparam logic [10:0] OFS_CSR_CTRL         = 11'h014;
  localparam logic [10:0] OFS_CFG_ROM_HEADER   = 11'h018;
  localparam logic [10:0] OFS_BUS_IDENTIFIER   = 11'h01C;
  localparam logic [10:0] OFS_BUS_OPTIONS      = 11'h020;
  localparam logic [10:0] OFS_UID_UPPER        = 11'h024;
  localparam logic [10:0] OFS_UID_LOWER        = 11'h028;
  localparam logic [10:0] OFS_CFG_ROM_MAP      = 11'h034;
  localparam logic [10:0] OFS_POSTED_WR_LOWER  = 11'h038;
  localparam logic [10:0] OFS_POSTED_WR_UPPER  = 11'h03C;
  localparam logic [10:0] OFS_MAKER_ID         = 11'h040;
  localparam logic [10:0] OFS_HOST_CTRL_SET    = 11'h050;
  localparam logic [10:0] OFS_HOST_CTRL_CLEAR  = 11'h054;
  localparam logic [10:0] OFS_INT_EVENT_SET    = 11'h080;
  localparam logic [10:0] OFS_INT_EVENT_CLEAR  = 11'h084;
  localparam logic [10:0] OFS_INT_MASK_SET     = 11'h088;
  localparam logic [10:0] OFS_INT_MASK_CLEAR   = 11'h08C;

  localparam logic [31:0] ZERO_WORD            = 32'h0000_0000;
  localparam logic [31:0] ASYNC_TX_RETRY_RESET = 32'h0000_0000;
  localparam logic [31:0] INT_RESET            = 32'h0000_0000;

  // plain storage words live in the register file, indexed by offset bits 5..2
  localparam int          STORE_DEPTH          = 16;
  localparam int          STORE_AW             = 4;

endpackage : ohcirb_pkg

// ===== rtl/ohcirb_store.sv
// small register file for the plain read/write window words
`timescale 1ns/10ps
`default_nettype none
module ohcirb_store #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  input  wire logic               i_we,
  input  wire logic [AW-1:0]      i_waddr,
  input  wire logic [WIDTH/8-1:0] i_be,
  input  wire logic [WIDTH-1:0]   i_wdata,
  input  wire logic [AW-1:0]      i_raddr,
  output logic      [WIDTH-1:0]   o_rdata
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rdata;

  for (genvar e = 0; e < DEPTH; e++) begin : g_entry
    logic [WIDTH-1:0] next_word;
    always_comb begin
      next_word = mem[e];
      if (i_we && (i_waddr == AW'(e))) begin
        for (int b = 0; b < WIDTH/8; b++) begin
          if (i_be[b]) begin
            next_word[b*8 +: 8] = i_wdata[b*8 +: 8];
          end
        end
      end
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        mem[e] <= '0;
      end else begin
        mem[e] <= next_word;
      end
    end
  end

  always_comb begin
    next_rdata = mem[i_raddr];
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule // ohcirb_store
`default_nettype wire
